// ### nttbf_pkg.sv
// Shared constants and types for the nine-track block format logic.
`default_nettype none
package nttbf_pkg;
    // Word and frame geometry.
    localparam int WORD_W = 30;
    localparam int DATA_W = 8;
    localparam int ACC_W = 38;
    localparam int UNIT_W = 4;
    localparam int NUM_UNITS = 16;
    localparam int FMT_BIT = 10;
    localparam int GRP_WORDS = 4;
    localparam int GRP_FRAMES = 15;
    // Accumulator fill levels, in bits.
    localparam logic [5:0] FILL_FRAME = 6'h08;
    localparam logic [5:0] FILL_WORD = 6'h1e;
    localparam logic [5:0] FILL_NONE = 6'h00;
    // Check frame slots counted from the final data frame.
    localparam logic [3:0] DIAG_SLOT = 4'h4;
    localparam logic [3:0] LONG_SLOT = 4'h8;
    // Recording density and interblock gap.
    localparam int DENSITY_FPI = 800;
    localparam int GAP_MILLI_IN = 600;
    localparam int GAP_FRAMES = GAP_MILLI_IN * DENSITY_FPI / 1000;
    localparam logic [9:0] GAP_LAST = 10'(GAP_FRAMES - 1);
    // System clock.
    localparam int CLK_PERIOD_NS = 40;
    localparam int FRAME_DIV_DEF = 16;

    typedef enum logic [1:0] {
        OP_WRITE = 2'b00,
        OP_READ = 2'b01,
        OP_BOOT = 2'b10
    } nttbf_op_e;

    typedef struct packed {
        logic parity;
        logic [DATA_W-1:0] data;
    } nttbf_frame_s;

    typedef struct packed {
        nttbf_op_e op;
        logic [UNIT_W-1:0] unit;
        logic [WORD_W-1:0] func;
    } nttbf_cmd_s;

    typedef struct packed {
        logic unit_err;
        logic lateral_err;
        logic check_err;
        logic parity_err;
    } nttbf_status_s;
endpackage
`default_nettype wire

// ### nttbf_check.sv
// Diagonal and longitudinal check frame accumulator.
`timescale 1ns/100ps
`default_nettype none
module nttbf_check (
    input wire logic clock,
    input wire logic nrst,
    input wire logic clear,
    input wire logic step,
    input wire nttbf_pkg::nttbf_frame_s frame_in,
    output nttbf_pkg::nttbf_frame_s diag,
    output nttbf_pkg::nttbf_frame_s long_chk
);
    import nttbf_pkg::*;

    // Diagonal value rotates one track per frame so a skewed bit shows up.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            diag <= '0;
        end else if (clear) begin
            diag <= '0;
        end else if (step) begin
            diag <= {diag[DATA_W-1:0], diag.parity} ^ frame_in;
        end
    end

    // Longitudinal value is the plain per-track exclusive or.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            long_chk <= '0;
        end else if (clear) begin
            long_chk <= '0;
        end else if (step) begin
            long_chk <= long_chk ^ frame_in;
        end
    end
endmodule
`default_nettype wire

// ### nttbf_core.sv
// Nine-track block framer: packs, unpacks and checks tape frames.
// Overview of operation
// - Each data frame holds eight data bits plus one odd parity bit.
// - Four processor words map onto fifteen tape frames, both directions.
// - Diagonal check updates per data frame, written fourth slot after.
// - Longitudinal check frame written eighth slot after last data frame.
// - Forward read recomputes both checks; mismatch reports parity error.
// - Nine-track handling uses 800 frames per inch, odd parity only.
// - Blocks are separated by a 0.6 inch gap.
// - Bit 10 of a transfer function word selects nine-track format.
// - Bootstrap takes its format from the track format selector switch.
// - Write holds off tape motion until the first word arrives.
// - First read frame lands in bits 29..22; partial word zero filled.
// - Write pads a partial last frame with two, four or six zeros.
`timescale 1ns/100ps
`default_nettype none
module nttbf_core #(
    parameter int FRAME_DIV = nttbf_pkg::FRAME_DIV_DEF
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire nttbf_pkg::nttbf_cmd_s cmd,
    output logic cmd_ready,
    input wire logic track_format_selector_switch,
    input wire logic [nttbf_pkg::NUM_UNITS-1:0] unit_9trk_cap,
    input wire logic wr_valid,
    input wire logic [nttbf_pkg::WORD_W-1:0] wr_data,
    input wire logic wr_last,
    output logic wr_ready,
    output nttbf_pkg::nttbf_frame_s tape_frame,
    output logic tape_write_strobe,
    output logic tape_motion,
    output logic [nttbf_pkg::UNIT_W-1:0] tape_unit,
    input wire nttbf_pkg::nttbf_frame_s tape_frame_in,
    input wire logic tape_read_strobe,
    input wire logic tape_block_end,
    output logic rd_valid,
    output logic [nttbf_pkg::WORD_W-1:0] rd_data,
    output logic format_9trk,
    output logic done,
    output nttbf_pkg::nttbf_status_s status
);
    import nttbf_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WDATA = 3'b001,
        ST_WTRAIL = 3'b010,
        ST_WGAP = 3'b011,
        ST_RDATA = 3'b100,
        ST_DONE = 3'b101
    } nttbf_state_e;

    localparam logic [15:0] DIV_LAST = 16'(FRAME_DIV - 1);

    nttbf_state_e state_q, state_d;
    logic [15:0] div_q;
    logic tick, take, fmt9, unit_ok, emit, wfin, rpush;
    logic [ACC_W-1:0] wacc_q, racc_q, racc_p;
    logic [5:0] wcnt_q, rcnt_q, rcnt_p;
    logic wend_q;
    logic [3:0] slot_q;
    logic [9:0] gap_q;
    nttbf_frame_s wframe, hist0_q, hist1_q, step_frame, diag_w, long_w;
    logic [1:0] hcnt_q;
    logic check_bad;

    ////////////////////////////////////////////////////////////////////////
    // Frame clock and command decode.

    // One enable per frame cell; density fixes how far tape moves per cell.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            div_q <= '0;
        end else begin
            div_q <= (div_q == DIV_LAST) ? '0 : div_q + 16'h0001;
        end
    end
    assign tick = (div_q == DIV_LAST);

    assign cmd_ready = (state_q == ST_IDLE);
    assign take = cmd_valid && cmd_ready;
    // Bootstrap ignores the function word format bit.
    assign fmt9 = (cmd.op == OP_BOOT) ? track_format_selector_switch
                                      : cmd.func[FMT_BIT];
    assign unit_ok = unit_9trk_cap[cmd.unit];
    assign wr_ready = (state_q == ST_WDATA) && !wend_q && (wcnt_q < FILL_FRAME);
    // A frame goes out only once data has started tape motion.
    assign emit = (state_q == ST_WDATA) && tick && tape_motion &&
                  ((wcnt_q >= FILL_FRAME) || (wend_q && wcnt_q != FILL_NONE));
    assign wfin = emit && wend_q && (wcnt_q <= FILL_FRAME);
    assign wframe = {~^wacc_q[ACC_W-1 -: DATA_W],
                     wacc_q[ACC_W-1 -: DATA_W]};
    assign rpush = (state_q == ST_RDATA) && tape_read_strobe &&
                   (hcnt_q == 2'h2);
    assign step_frame = (state_q == ST_RDATA) ? hist1_q : wframe;
    assign check_bad = (hcnt_q != 2'h2) || (diag_w != hist1_q) ||
                       (long_w != hist0_q);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer.

    // Command, write data, trailer slots, gap, or read until block end.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (take) begin
                    if (!fmt9 || !unit_ok) begin
                        state_d = ST_DONE;
                    end else if (cmd.op == OP_WRITE) begin
                        state_d = ST_WDATA;
                    end else begin
                        state_d = ST_RDATA;
                    end
                end
            end
            ST_WDATA: begin
                if (wfin) begin
                    state_d = ST_WTRAIL;
                end
            end
            ST_WTRAIL: begin
                if (tick && slot_q == LONG_SLOT - 4'h1) begin
                    state_d = ST_WGAP;
                end
            end
            ST_WGAP: begin
                if (tick && gap_q == GAP_LAST) begin
                    state_d = ST_DONE;
                end
            end
            ST_RDATA: begin
                if (tape_block_end) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Latched command attributes shown to the rest of the control unit.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            format_9trk <= 1'b0;
            tape_unit <= '0;
        end else if (take) begin
            format_9trk <= fmt9;
            tape_unit <= cmd.unit;
        end
    end

    // Done is a single pulse as the sequencer returns to idle.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            done <= 1'b0;
        end else begin
            done <= (state_d == ST_DONE);
        end
    end

    // Motion waits for the first write word; a read starts it at once.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tape_motion <= 1'b0;
        end else if (state_q == ST_DONE) begin
            tape_motion <= 1'b0;
        end else if (take && fmt9 && unit_ok && cmd.op != OP_WRITE) begin
            tape_motion <= 1'b1;
        end else if (wr_valid && wr_ready) begin
            tape_motion <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write packing and trailer.

    // Words enter left aligned; 120 bits make exactly fifteen frames.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wacc_q <= '0;
            wcnt_q <= FILL_NONE;
            wend_q <= 1'b0;
        end else if (take) begin
            wacc_q <= '0;
            wcnt_q <= FILL_NONE;
            wend_q <= 1'b0;
        end else if (wr_valid && wr_ready) begin
            wacc_q <= wacc_q | ({wr_data, 8'h00} >> wcnt_q);
            wcnt_q <= wcnt_q + FILL_WORD;
            wend_q <= wr_last;
        end else if (emit) begin
            // Shifting leaves zeros behind, which pads a short final frame.
            wacc_q <= wacc_q << DATA_W;
            wcnt_q <= (wcnt_q >= FILL_FRAME) ? wcnt_q - FILL_FRAME : FILL_NONE;
        end
    end

    // Slot and gap counters run on frame enables after the last data frame.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            slot_q <= '0;
            gap_q <= '0;
        end else if (take) begin
            slot_q <= '0;
            gap_q <= '0;
        end else if (tick && state_q == ST_WTRAIL) begin
            slot_q <= slot_q + 4'h1;
        end else if (tick && state_q == ST_WGAP) begin
            gap_q <= gap_q + 10'h001;
        end
    end

    // Data frames, then diagonal and longitudinal frames at their slots.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tape_frame <= '0;
            tape_write_strobe <= 1'b0;
        end else begin
            tape_write_strobe <= 1'b0;
            if (emit) begin
                tape_frame <= wframe;
                tape_write_strobe <= 1'b1;
            end else if (tick && state_q == ST_WTRAIL) begin
                if (slot_q == DIAG_SLOT - 4'h1) begin
                    tape_frame <= diag_w;
                    tape_write_strobe <= 1'b1;
                end else if (slot_q == LONG_SLOT - 4'h1) begin
                    tape_frame <= long_w;
                    tape_write_strobe <= 1'b1;
                end
            end
        end
    end

    nttbf_check u_check (
        .clock(clock),
        .nrst(nrst),
        .clear(take),
        .step(emit || rpush),
        .frame_in(step_frame),
        .diag(diag_w),
        .long_chk(long_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read unpacking and checking.

    // The last two frames of a block are check frames, so data lags by two.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hist0_q <= '0;
            hist1_q <= '0;
            hcnt_q <= '0;
        end else if (take) begin
            hcnt_q <= '0;
        end else if (state_q == ST_RDATA && tape_read_strobe) begin
            hist0_q <= tape_frame_in;
            hist1_q <= hist0_q;
            hcnt_q <= (hcnt_q == 2'h2) ? hcnt_q : hcnt_q + 2'h1;
        end
    end

    assign racc_p = racc_q | ({hist1_q.data, 30'h0000_0000} >> rcnt_q);
    assign rcnt_p = rcnt_q + FILL_FRAME;

    // First frame lands in bits 29..22; a short tail word is zero filled.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            racc_q <= '0;
            rcnt_q <= FILL_NONE;
            rd_valid <= 1'b0;
            rd_data <= '0;
        end else begin
            rd_valid <= 1'b0;
            if (take) begin
                racc_q <= '0;
                rcnt_q <= FILL_NONE;
            end else if (rpush) begin
                if (rcnt_p >= FILL_WORD) begin
                    rd_valid <= 1'b1;
                    rd_data <= racc_p[ACC_W-1 -: WORD_W];
                    racc_q <= racc_p << WORD_W;
                    rcnt_q <= rcnt_p - FILL_WORD;
                end else begin
                    racc_q <= racc_p;
                    rcnt_q <= rcnt_p;
                end
            end else if (state_q == ST_RDATA && tape_block_end &&
                         rcnt_q != FILL_NONE) begin
                rd_valid <= 1'b1;
                rd_data <= racc_q[ACC_W-1 -: WORD_W];
                racc_q <= '0;
                rcnt_q <= FILL_NONE;
            end
        end
    end

    // Errors are sticky for one command; lateral or check failure is parity.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            status <= '0;
        end else if (take) begin
            status <= '0;
            status.unit_err <= fmt9 && !unit_ok;
        end else begin
            if (rpush && !(^hist1_q)) begin
                status.lateral_err <= 1'b1;
                status.parity_err <= 1'b1;
            end
            if (state_q == ST_RDATA && tape_block_end && check_bad) begin
                status.check_err <= 1'b1;
                status.parity_err <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    chk_odd_parity: assert property (
        tape_write_strobe && $past(state_q) == ST_WDATA |-> ^tape_frame)
        else $error("data frame written without odd parity");
    chk_motion_hold: assert property (
        $rose(tape_motion) && $past(state_q) == ST_WDATA
        |-> $past(wr_valid && wr_ready))
        else $error("tape moved before the first write word");
    // The final data frame also strobes in the first trailer cycle.
    chk_diag_slot: assert property (
        tape_write_strobe && state_q == ST_WTRAIL &&
        $past(state_q) == ST_WTRAIL
        |-> slot_q == DIAG_SLOT && tape_frame == diag_w)
        else $error("diagonal frame wrong or out of slot");
    chk_long_slot: assert property (
        tape_write_strobe && state_q == ST_WGAP
        |-> slot_q == LONG_SLOT && tape_frame == long_w)
        else $error("longitudinal frame wrong or out of slot");
    chk_gap_quiet: assert property (
        state_q == ST_WGAP && $past(state_q) == ST_WGAP
        |-> !tape_write_strobe)
        else $error("frame written inside the interblock gap");
    chk_read_check: assert property (
        state_q == ST_RDATA && tape_block_end && check_bad
        |=> status.parity_err && status.check_err)
        else $error("check frame mismatch not reported");
    chk_lateral_err: assert property (
        rpush && !(^hist1_q) |=> status.lateral_err && status.parity_err)
        else $error("lateral parity failure not reported");
    chk_fmt_bit: assert property (
        take && cmd.op != OP_BOOT |=> format_9trk == $past(cmd.func[FMT_BIT]))
        else $error("format not taken from function word");
    chk_boot_switch: assert property (
        take && cmd.op == OP_BOOT
        |=> format_9trk == $past(track_format_selector_switch))
        else $error("bootstrap format not taken from switch");
    chk_unit_cap: assert property (
        take && fmt9 && !unit_ok |=> status.unit_err && state_q == ST_DONE)
        else $error("incapable unit accepted for nine-track");

    cov_write_block: cover property (
        state_q == ST_WGAP && state_d == ST_DONE);
    cov_read_tail: cover property (
        state_q == ST_RDATA && tape_block_end && rcnt_q != FILL_NONE);
    cov_unit_reject: cover property (take && fmt9 && !unit_ok);
endmodule
`default_nettype wire

// ### nttbf_chan_model.sv
// Processor channel model: builds function words and offers write words.
`timescale 1ns/100ps
`default_nettype none
module nttbf_chan_model #(
    // Odd parity and 800 fpi request bits; their layout lies outside this
    // block, so the code is a parameter.
    parameter logic [nttbf_pkg::WORD_W-1:0] MODE_BITS = '0
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic slow,
    input wire logic wr_ready,
    output logic wr_valid,
    output logic [nttbf_pkg::WORD_W-1:0] wr_data,
    output logic wr_last
);
    import nttbf_pkg::*;
    logic [WORD_W-1:0] q[$];
    logic [31:0] s = 32'h0000_6546;
    int hold_n = 0;

    ////////////////////////////////////////////////////////////////////////
    // MODE_BITS plus the format bit; translation stays off for these units.
    function automatic logic [WORD_W-1:0] func_word(input logic nine);
        logic [WORD_W-1:0] f;
        f = MODE_BITS;
        f[FMT_BIT] = nine;
        return f;
    endfunction

    task automatic push(input logic [WORD_W-1:0] w);
        q.push_back(w);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // A word stays steady until taken. Idle data toggles every cycle so a
    // framer that samples it outside a handshake picks up garbage.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wr_valid <= 1'b0;
            wr_data <= '0;
            wr_last <= 1'b0;
        end else if (wr_valid && wr_ready) begin
            void'(q.pop_front());
            wr_valid <= 1'b0;
            wr_data <= ~wr_data;
            wr_last <= 1'b0;
            s = s ^ (s << 13);
            s = s ^ (s >> 17);
            s = s ^ (s << 5);
            hold_n = slow ? int'(s[1:0]) : 0;
        end else if (!wr_valid && q.size() != 0 && hold_n == 0) begin
            wr_valid <= 1'b1;
            wr_data <= q[0];
            wr_last <= (q.size() == 1);
        end else if (!wr_valid) begin
            wr_data <= ~wr_data;
            if (hold_n > 0) begin
                hold_n--;
            end
        end
    end
endmodule
`default_nettype wire

// ### nttbf_core_tb.sv
// Self-checking testbench for the nine-track block framer.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module nttbf_core_tb;
    import nttbf_pkg::*;
    localparam int FD = 2;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic cmd_valid = 1'b0;
    nttbf_cmd_s cmd = '0;
    logic sw = 1'b0;
    logic slow = 1'b0;
    logic [15:0] cap = '0;
    nttbf_frame_s tfi = '0;
    logic rds = 1'b0;
    logic bend = 1'b0;
    logic cmd_ready, wr_valid, wr_last, wr_ready, tws, tape_motion;
    logic rd_valid, format_9trk, done;
    logic [WORD_W-1:0] wr_data, rd_data;
    logic [UNIT_W-1:0] tape_unit;
    nttbf_frame_s tape_frame;
    nttbf_status_s status;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    int k, td;
    logic [31:0] seed = 32'h0000_6546;
    logic [31:0] tmp;
    nttbf_frame_s fq[$], eq[$];
    int ft[$];
    logic [WORD_W-1:0] rq[$], wq[$], xq[$];

    always #20 clock = ~clock;

    nttbf_core #(.FRAME_DIV(FD)) DUT (.clock(clock), .nrst(nrst),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
        .track_format_selector_switch(sw), .unit_9trk_cap(cap),
        .wr_valid(wr_valid), .wr_data(wr_data), .wr_last(wr_last),
        .wr_ready(wr_ready), .tape_frame(tape_frame),
        .tape_write_strobe(tws), .tape_motion(tape_motion),
        .tape_unit(tape_unit), .tape_frame_in(tfi), .tape_read_strobe(rds),
        .tape_block_end(bend), .rd_valid(rd_valid), .rd_data(rd_data),
        .format_9trk(format_9trk), .done(done), .status(status));

    nttbf_chan_model u_chan (.clock(clock), .nrst(nrst), .slow(slow),
        .wr_ready(wr_ready), .wr_valid(wr_valid), .wr_data(wr_data),
        .wr_last(wr_last));

    ////////////////////////////////////////////////////////////////////////
    // Capture written frames with their cycle and every word read back.
    always @(posedge clock) begin
        cyc++;
        if (tws) begin
            fq.push_back(tape_frame);
            ft.push_back(cyc);
        end
        if (rd_valid) begin
            rq.push_back(rd_data);
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Odd lateral parity makes every frame carry an odd count of ones.
    function automatic nttbf_frame_s fr(input logic [7:0] d);
        return {~^d, d};
    endfunction

    // Appends the diagonal (rotate then xor) and longitudinal frames.
    function automatic void add_checks();
        nttbf_frame_s dg, lg;
        dg = '0;
        lg = '0;
        foreach (eq[i]) begin
            dg = {dg[7:0], dg[8]} ^ eq[i];
            lg = lg ^ eq[i];
        end
        eq.push_back(dg);
        eq.push_back(lg);
    endfunction

    // Words go out MSB first; the last frame is zero padded.
    function automatic void enc();
        logic b[$];
        logic [7:0] d;
        eq.delete();
        foreach (wq[w]) for (int i = 29; i >= 0; i--) b.push_back(wq[w][i]);
        while (b.size() % 8 != 0) b.push_back(1'b0);
        while (b.size() != 0) begin
            for (int j = 0; j < 8; j++) d = {d[6:0], b.pop_front()};
            eq.push_back(fr(d));
        end
        add_checks();
    endfunction

    // Frame data regrouped into words, a short last word zero filled.
    function automatic void dec(input int nf);
        logic b[$];
        logic [WORD_W-1:0] w;
        xq.delete();
        for (int f = 0; f < nf; f++)
            for (int i = 7; i >= 0; i--) b.push_back(eq[f].data[i]);
        while (b.size() != 0) begin
            for (int i = 29; i >= 0; i--) w[i] = b.size() ? b.pop_front() : 0;
            xq.push_back(w);
        end
    endfunction

    task automatic test_done();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cmd_go(input nttbf_op_e op, input logic [3:0] u,
                          input logic f9, input logic s);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd <= '{op, u, u_chan.func_word(f9)};
        sw <= s;
        @(posedge clock);
        cmd_valid <= 1'b0;
        fq.delete();
        ft.delete();
        rq.delete();
    endtask

    // Counts edges from the command take to the done pulse. Done may rise
    // at the edge the caller returns on, so it is looked at before waiting.
    task automatic wait_done(input int mx);
        for (k = 0; k < mx; k++) begin
            #1;
            if (done === 1'b1) begin
                // Strobes are logged one edge late; done is counted alike.
                td = cyc + 1;
                return;
            end
            @(posedge clock);
        end
        n_fail++;
        test_done();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // A write of n words, checked frame by frame with trailer timing.
    task automatic do_write(input int n);
        int m;
        cmd_go(OP_WRITE, 4'h0, 1'b1, 1'b0);
        repeat (10) @(posedge clock);
        slow <= n[0];
        #1;
        `CHK(tape_motion, 1'b0)
        `CHK(format_9trk, 1'b1)
        wq.delete();
        for (int i = 0; i < n; i++) begin
            tmp = xs();
            wq.push_back(tmp[29:0]);
        end
        enc();
        foreach (wq[i]) u_chan.push(wq[i]);
        wait_done(4000);
        m = ft.size();
        `CHK(m, eq.size())
        foreach (eq[i]) `CHK(fq[i], eq[i])
        `CHK(ft[m-2] - ft[m-3], 4 * FD)
        `CHK(ft[m-1] - ft[m-2], 4 * FD)
        `CHK(td - ft[m-1], GAP_FRAMES * FD)
        `CHK(status, 4'h0)
    endtask

    // A read of nf data frames; mode 1 spoils a parity bit, 2 the check.
    task automatic do_read(input nttbf_op_e op, input logic f9,
                           input logic s, input int nf, input int mode);
        cmd_go(op, 4'h0, f9, s);
        eq.delete();
        for (int i = 0; i < nf; i++) begin
            tmp = xs();
            eq.push_back(fr(tmp[7:0]));
        end
        add_checks();
        dec(nf);
        if (mode == 1) eq[3].parity = ~eq[3].parity;
        if (mode == 2) eq[nf+1].data[0] = ~eq[nf+1].data[0];
        foreach (eq[i]) begin
            @(posedge clock);
            rds <= 1'b1;
            tfi <= eq[i];
            @(posedge clock);
            rds <= 1'b0;
            tfi <= ~eq[i];
        end
        @(posedge clock);
        bend <= 1'b1;
        @(posedge clock);
        bend <= 1'b0;
        wait_done(50);
        // The zero-filled tail word is logged one edge after done.
        @(posedge clock);
        #1;
        `CHK(rq.size(), xq.size())
        foreach (xq[i]) `CHK(rq[i], xq[i])
        `CHK(status, (mode == 1) ? 4'h7 : (mode == 2) ? 4'h3 : 4'h0)
    endtask

    // Commands that end at once without tape action.
    task automatic do_rej(input nttbf_op_e op, input logic [3:0] u,
        input logic f9, input logic s, input logic fmt, input logic [3:0] st);
        cmd_go(op, u, f9, s);
        wait_done(10);
        `CHK(k, 0)
        `CHK(format_9trk, fmt)
        `CHK(tape_unit, u)
        `CHK(status, st)
        `CHK(fq.size(), 0)
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: writes covering every pad length, reads, refusals.
    initial begin
        repeat (5) @(posedge clock);
        tmp = xs();
        nrst <= 1'b1;
        cap <= {1'b0, tmp[14:1], 1'b1};
        #1;
        `CHK(cmd_ready, 1'b1)
        `CHK(tape_motion, 1'b0)
        for (int n = 1; n <= 5; n++) do_write(n);
        for (int md = 0; md < 3; md++) do_read(OP_READ, 1'b1, 1'b0, 15 + md, md);
        do_rej(OP_WRITE, 4'h0, 1'b0, 1'b1, 1'b0, 4'h0);
        do_rej(OP_WRITE, 4'hf, 1'b1, 1'b0, 1'b1, 4'h8);
        do_rej(OP_BOOT, 4'h0, 1'b1, 1'b0, 1'b0, 4'h0);
        do_read(OP_BOOT, 1'b0, 1'b1, 16, 0);
        test_done();
    end
endmodule
`default_nettype wire
